/* rtl/cpusup_top.sv */
// Processor supervisor: stretched system reset, watchdog, power-fail warning.
// Assumes all inputs are asynchronous pins; analog detectors sit outside.
// Function
// - Assert reset while supply low or button low
// - Hold reset 200 ms after both clear
// - Stretch debounces the manual reset button
// - Any kick edge restarts the watchdog count
// - Kick static past timeout drives expired low
// - Expired stays low until next kick edge; floating kick disables watchdog
// - Supply low forces expired low until valid
// - Active-high reset is exact complement
// - Warning high while sense above reference
// - Power-fail path independent of everything else
// - Watchdog timeout nominally 1.6 s
// - Stretch lasts 140 to 280 ms
`timescale 1ns/1ps
module cpusup_top #(
   parameter bit WD_VARIANT = 1'b1,
   parameter int unsigned TICK_CYCLES = cpusup_pkg::TICK_CYCLES,
   parameter int unsigned STRETCH_TICKS = cpusup_pkg::STRETCH_TICKS,
   parameter int unsigned WD_TICKS = cpusup_pkg::WD_TICKS
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic supply_low,
   input wire logic manual_reset_n,
   input wire logic wd_kick_in,
   input wire logic wd_kick_float,
   input wire logic pwrfail_sense_in,
   output logic reset_n,
   output logic reset_hi,
   output logic wd_expired_n,
   output logic pwrfail_warn_n
);
   logic [cpusup_pkg::SYN_WIDTH-1:0] pin_raw;
   logic [cpusup_pkg::SYN_WIDTH-1:0] pin_s;
   logic sup_low_s;
   logic mr_n_s;
   logic kick_s;
   logic float_s;
   logic pf_s;

   assign pin_raw = {pwrfail_sense_in, wd_kick_float, wd_kick_in, manual_reset_n, supply_low};

   // Every pin is asynchronous to clk
   genvar gi;
   generate
      for (gi = 0; gi < cpusup_pkg::SYN_WIDTH; gi++) begin : g_sync
         cpusup_sync2 u_sync (
            .clk(clk),
            .rst_b(rst_b),
            .d(pin_raw[gi]),
            .q(pin_s[gi])
         );
      end
   endgenerate

   assign sup_low_s = pin_s[cpusup_pkg::SYN_SUPPLY_LOW];
   assign mr_n_s = pin_s[cpusup_pkg::SYN_MANUAL_RST];
   assign kick_s = pin_s[cpusup_pkg::SYN_KICK];
   assign float_s = pin_s[cpusup_pkg::SYN_KICK_FLOAT];
   assign pf_s = pin_s[cpusup_pkg::SYN_PWRFAIL];

   // Free-running timebase; coarse ticks keep the long counters narrow
   logic [15:0] tb_cnt;
   logic [15:0] next_tb_cnt;
   logic tick;

   always_comb begin
      tick = (tb_cnt == 16'(TICK_CYCLES - 1));
      next_tb_cnt = tick ? 16'h0000 : tb_cnt + 16'h0001;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tb_cnt <= 16'h0000;
      end else begin
         tb_cnt <= next_tb_cnt;
      end
   end

   // Reset sequencer
   cpusup_pkg::cpusup_rst_state_t state;
   cpusup_pkg::cpusup_rst_state_t next_state;
   logic [31:0] st_cnt;
   logic [31:0] next_st_cnt;
   logic hold;
   logic next_reset_n;
   logic next_reset_hi;

   always_comb begin
      hold = sup_low_s || !mr_n_s;
      next_state = state;
      next_st_cnt = st_cnt;
      case (state)
         cpusup_pkg::CPUSUP_HOLD: begin
            next_st_cnt = 32'h0000_0000;
            if (!hold) begin
               next_state = cpusup_pkg::CPUSUP_STRETCH;
            end
         end
         cpusup_pkg::CPUSUP_STRETCH: begin
            // Any bounce back to low restarts the full stretch
            if (hold) begin
               next_state = cpusup_pkg::CPUSUP_HOLD;
               next_st_cnt = 32'h0000_0000;
            end else if (tick) begin
               if (st_cnt == 32'(STRETCH_TICKS - 1)) begin
                  next_state = cpusup_pkg::CPUSUP_RUN;
               end else begin
                  next_st_cnt = st_cnt + 32'h0000_0001;
               end
            end
         end
         default: begin
            if (hold) begin
               next_state = cpusup_pkg::CPUSUP_HOLD;
            end
         end
      endcase
      next_reset_n = (next_state == cpusup_pkg::CPUSUP_RUN);
      next_reset_hi = WD_VARIANT ? 1'b0 : !next_reset_n;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= cpusup_pkg::CPUSUP_HOLD;
         st_cnt <= 32'h0000_0000;
         reset_n <= 1'b0;
         // Variant 0 starts asserted so the complement is exact from reset
         reset_hi <= !WD_VARIANT;
      end else begin
         state <= next_state;
         st_cnt <= next_st_cnt;
         reset_n <= next_reset_n;
         reset_hi <= next_reset_hi;
      end
   end

   // Watchdog
   logic kick_d;
   logic kick_edge;
   logic [31:0] wd_cnt;
   logic [31:0] next_wd_cnt;
   logic wd_exp;
   logic next_wd_exp;
   logic next_wd_expired_n;

   always_comb begin
      kick_edge = kick_s ^ kick_d;
      next_wd_cnt = wd_cnt;
      next_wd_exp = wd_exp;
      if (sup_low_s || float_s) begin
         // Count restarts once supply is valid again and the kick pin no longer floats
         next_wd_cnt = 32'h0000_0000;
         next_wd_exp = 1'b0;
      end else if (kick_edge) begin
         next_wd_cnt = 32'h0000_0000;
         next_wd_exp = 1'b0;
      end else if (tick && !wd_exp) begin
         if (wd_cnt == 32'(WD_TICKS - 1)) begin
            next_wd_exp = 1'b1;
         end else begin
            next_wd_cnt = wd_cnt + 32'h0000_0001;
         end
      end
      // Unused variant parks the expired pin high
      next_wd_expired_n = WD_VARIANT ? !(sup_low_s || next_wd_exp) : 1'b1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         kick_d <= 1'b0;
         wd_cnt <= 32'h0000_0000;
         wd_exp <= 1'b0;
         wd_expired_n <= 1'b1;
      end else begin
         kick_d <= kick_s;
         wd_cnt <= next_wd_cnt;
         wd_exp <= next_wd_exp;
         wd_expired_n <= next_wd_expired_n;
      end
   end

   // Power-fail warning: touches no other state
   logic next_pwrfail_warn_n;

   always_comb begin
      next_pwrfail_warn_n = pf_s;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwrfail_warn_n <= 1'b0;
      end else begin
         pwrfail_warn_n <= next_pwrfail_warn_n;
      end
   end

   // Checks
   sequence s_hold_release;
      hold ##1 !hold;
   endsequence

   sequence s_kick_toggle;
      kick_s != kick_d;
   endsequence

   a_reset_on_hold: assert property (@(posedge clk) disable iff (!rst_b)
      hold |=> !reset_n)
      else $error("reset released while hold active");

   a_stretch_after_release: assert property (@(posedge clk) disable iff (!rst_b)
      s_hold_release |=> !reset_n [*8])
      else $error("reset not stretched after release");

   a_stretch_bounce: assert property (@(posedge clk) disable iff (!rst_b)
      (state == cpusup_pkg::CPUSUP_STRETCH && hold) |=> (state == cpusup_pkg::CPUSUP_HOLD && st_cnt == 32'h0000_0000))
      else $error("bounce did not restart stretch");

   a_stretch_end: assert property (@(posedge clk) disable iff (!rst_b)
      (state == cpusup_pkg::CPUSUP_STRETCH && tick && !hold && st_cnt == 32'(STRETCH_TICKS - 1))
      |=> reset_n)
      else $error("stretch did not end on count");

   a_kick_restart: assert property (@(posedge clk) disable iff (!rst_b)
      s_kick_toggle |=> (wd_cnt == 32'h0000_0000 && !wd_exp))
      else $error("kick edge did not restart watchdog");

   a_wd_timeout: assert property (@(posedge clk) disable iff (!rst_b)
      (WD_VARIANT && tick && wd_cnt == 32'(WD_TICKS - 1) && kick_s == kick_d && !float_s)
      |=> !wd_expired_n)
      else $error("watchdog did not expire on timeout");

   a_float_disable: assert property (@(posedge clk) disable iff (!rst_b)
      (float_s && !sup_low_s) |=> (wd_expired_n && wd_cnt == 32'h0000_0000))
      else $error("floating kick did not disable watchdog");

   a_supply_expired: assert property (@(posedge clk) disable iff (!rst_b)
      (WD_VARIANT && sup_low_s) |=> !wd_expired_n)
      else $error("expired not low during supply low");

   a_high_complement: assert property (@(posedge clk) disable iff (!rst_b)
      !WD_VARIANT |-> (reset_hi == !reset_n))
      else $error("active-high reset not complement");

   a_pwrfail_follow: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> (pwrfail_warn_n == $past(pf_s)))
      else $error("warning does not follow comparator");

   a_pwrfail_indep: assert property (@(posedge clk) disable iff (!rst_b)
      ($stable(pf_s) && $past(pf_s) == pwrfail_warn_n) |=> $stable(pwrfail_warn_n))
      else $error("warning changed without comparator change");

endmodule : cpusup_top

/* inc/cpusup_pkg.sv */
// Constants for the processor supervisor: timebase, stretch and watchdog timing.
// Assumes a 200 MHz system clock.
package cpusup_pkg;

   // System clock
   localparam int unsigned CLK_MHZ = 200;

   // Timebase tick period and its length in clock cycles
   localparam int unsigned TICK_US = 1;
   localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;

   // Reset stretch: nominal 200 ms, window 140 ms to 280 ms
   localparam int unsigned STRETCH_MS = 200;
   localparam int unsigned STRETCH_MIN_MS = 140;
   localparam int unsigned STRETCH_MAX_MS = 280;
   localparam int unsigned STRETCH_TICKS = STRETCH_MS * 1000 / TICK_US;

   // Watchdog timeout: nominal 1.6 s, window 1.0 s to 2.25 s
   localparam int unsigned WD_TIMEOUT_MS = 1600;
   localparam int unsigned WD_TICKS = WD_TIMEOUT_MS * 1000 / TICK_US;

   // Shortest kick pulse that must restart the watchdog, rounded up to cycles
   localparam int unsigned KICK_MIN_NS = 50;
   localparam int unsigned KICK_MIN_CYCLES = (KICK_MIN_NS * CLK_MHZ + 999) / 1000;

   // Synchroniser bit positions
   localparam int unsigned SYN_SUPPLY_LOW = 0;
   localparam int unsigned SYN_MANUAL_RST = 1;
   localparam int unsigned SYN_KICK = 2;
   localparam int unsigned SYN_KICK_FLOAT = 3;
   localparam int unsigned SYN_PWRFAIL = 4;
   localparam int unsigned SYN_WIDTH = 5;

   // Reset value of the synchroniser flops
   localparam logic SYN_RST_VAL = 1'b0;

   typedef enum logic [1:0] {
      CPUSUP_HOLD,
      CPUSUP_STRETCH,
      CPUSUP_RUN
   } cpusup_rst_state_t;

endpackage : cpusup_pkg

/* rtl/cpusup_sync2.sv */
// Two-flop synchroniser for one asynchronous pin.
// Assumes the destination clock is clk; first flop feeds only the second.
`timescale 1ns/1ps
module cpusup_sync2 (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic d,
   output logic q
);
   logic meta;
   logic next_meta;
   logic next_q;

   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= cpusup_pkg::SYN_RST_VAL;
         q <= cpusup_pkg::SYN_RST_VAL;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule : cpusup_sync2

/* tb/cpusup_cpu_model.sv */
// Processor model on the far side: kicks the watchdog while out of reset.
// Assumes clk is the supervisor clock; kick_gap of zero stops the kicks.
`timescale 1ns/1ps
module cpusup_cpu_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wd_expired_n,
   input wire logic [15:0] kick_gap,
   input wire logic loop_en,
   output logic wd_kick_in,
   output logic manual_reset_n
);
   logic [15:0] gap_cnt;
   initial begin
      wd_kick_in = 1'b0;
      gap_cnt = 16'h0000;
   end
   // A processor held in reset cannot kick
   always @(posedge clk) begin
      if (reset_n !== 1'b1 || kick_gap == 16'h0000) begin
         gap_cnt <= 16'h0000;
      end else if (gap_cnt + 16'h0001 >= kick_gap) begin
         gap_cnt <= 16'h0000;
         wd_kick_in <= #1 ~wd_kick_in;
      end else begin
         gap_cnt <= gap_cnt + 16'h0001;
      end
   end
   // Timeout looped into the button input
   assign manual_reset_n = loop_en ? wd_expired_n : 1'b1;
endmodule : cpusup_cpu_model

/* tb/testbench.sv */
// Bench for the processor supervisor, both build variants side by side.
// Assumes shortened timers; the processor model drives the kick pin.
`timescale 1ns/1ps
module testbench;
   // Shortened timers: 4-cycle tick, 20-tick stretch, 50-tick timeout
   localparam int unsigned TB_TICK = 4;
   localparam int unsigned TB_STRETCH = 20;
   localparam int unsigned TB_WD = 50;
   localparam int unsigned STR_CYC = TB_TICK * TB_STRETCH;
   localparam int unsigned WD_CYC = TB_TICK * TB_WD;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic supply_low = 1'b0;
   logic btn_n = 1'b1;
   logic wd_kick_float = 1'b0;
   logic pwrfail_sense_in = 1'b1;
   logic [15:0] kick_gap = 16'h0064;
   logic loop_en = 1'b0;
   logic wd_kick_in, model_mr_n, manual_reset_n;
   logic reset_n, reset_hi, wd_expired_n, pwrfail_warn_n;
   logic hi_reset_n, hi_reset_hi, hi_wd_n, hi_warn_n;
   int err_count = 0;
   int samples_checked = 0;
   always #2.5 clk = ~clk;
   assign manual_reset_n = btn_n & model_mr_n;
   cpusup_top #(.TICK_CYCLES(TB_TICK), .STRETCH_TICKS(TB_STRETCH), .WD_TICKS(TB_WD)) DUT (
      .clk(clk), .rst_b(rst_b), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
      .wd_kick_in(wd_kick_in), .wd_kick_float(wd_kick_float), .pwrfail_sense_in(pwrfail_sense_in),
      .reset_n(reset_n), .reset_hi(reset_hi), .wd_expired_n(wd_expired_n),
      .pwrfail_warn_n(pwrfail_warn_n));
   cpusup_top #(.WD_VARIANT(1'b0), .TICK_CYCLES(TB_TICK), .STRETCH_TICKS(TB_STRETCH),
      .WD_TICKS(TB_WD)) DUT_HI (
      .clk(clk), .rst_b(rst_b), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
      .wd_kick_in(wd_kick_in), .wd_kick_float(wd_kick_float), .pwrfail_sense_in(pwrfail_sense_in),
      .reset_n(hi_reset_n), .reset_hi(hi_reset_hi), .wd_expired_n(hi_wd_n),
      .pwrfail_warn_n(hi_warn_n));
   cpusup_cpu_model cpu (.clk(clk), .reset_n(reset_n), .wd_expired_n(wd_expired_n),
      .kick_gap(kick_gap), .loop_en(loop_en), .wd_kick_in(wd_kick_in),
      .manual_reset_n(model_mr_n));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      if (err_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   // Reset must be stretched after the button or supply clears
   task automatic expect_stretch;
      cyc(STR_CYC - 6);
      chk(reset_n, 1'b0);
      cyc(16);
      chk(reset_n, 1'b1);
   endtask : expect_stretch
   task automatic t_startup;
      cyc(16);
      rst_b = 1'b1;
      expect_stretch();
      chk(reset_hi, 1'b0);
      chk(pwrfail_warn_n, 1'b1);
   endtask : t_startup
   task automatic t_pwrfail;
      pwrfail_sense_in = 1'b0;
      cyc(4);
      chk(pwrfail_warn_n, 1'b0);
      chk(hi_warn_n, 1'b0);
      chk(reset_n, 1'b1);
      chk(wd_expired_n, 1'b1);
      pwrfail_sense_in = 1'b1;
      cyc(4);
      chk(pwrfail_warn_n, 1'b1);
      chk(hi_warn_n, 1'b1);
   endtask : t_pwrfail
   task automatic t_watchdog;
      kick_gap = 16'h000A;
      cyc(300);
      chk(wd_expired_n, 1'b1);
      kick_gap = 16'h0096;
      cyc(500);
      chk(wd_expired_n, 1'b1);
      @(wd_kick_in);
      kick_gap = 16'h0000;
      cyc(WD_CYC - 10);
      chk(wd_expired_n, 1'b1);
      cyc(25);
      chk(wd_expired_n, 1'b0);
      kick_gap = 16'h0064;
      cyc(105);
      chk(wd_expired_n, 1'b1);
   endtask : t_watchdog
   task automatic t_float;
      kick_gap = 16'h0000;
      wd_kick_float = 1'b1;
      cyc(WD_CYC + 50);
      chk(wd_expired_n, 1'b1);
      wd_kick_float = 1'b0;
      kick_gap = 16'h0064;
   endtask : t_float
   // A bounce in mid-stretch must restart the whole stretch
   task automatic t_button;
      btn_n = 1'b0;
      cyc(4);
      chk(reset_n, 1'b0);
      chk(hi_reset_hi, ~hi_reset_n);
      btn_n = 1'b1;
      cyc(40);
      btn_n = 1'b0;
      cyc(5);
      btn_n = 1'b1;
      expect_stretch();
   endtask : t_button
   task automatic t_supply;
      supply_low = 1'b1;
      cyc(4);
      chk(reset_n, 1'b0);
      chk(wd_expired_n, 1'b0);
      chk(hi_reset_hi, 1'b1);
      chk(hi_wd_n, 1'b1);
      cyc(WD_CYC + 50);
      chk(wd_expired_n, 1'b0);
      supply_low = 1'b0;
      cyc(4);
      chk(wd_expired_n, 1'b1);
      expect_stretch();
   endtask : t_supply
   task automatic t_loop;
      kick_gap = 16'h0000;
      loop_en = 1'b1;
      cyc(WD_CYC + 15);
      chk(wd_expired_n, 1'b0);
      chk(reset_n, 1'b0);
      loop_en = 1'b0;
      expect_stretch();
      kick_gap = 16'h0064;
      cyc(105);
      chk(wd_expired_n, 1'b1);
   endtask : t_loop
   initial begin
      t_startup();
      t_pwrfail();
      t_watchdog();
      t_float();
      t_button();
      t_supply();
      t_loop();
      test_done();
   end
   // Whole sequence needs about 2500 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done();
   end
endmodule : testbench
